//--- tb/can_bus_model.sv
// Bus line model: another node, an open high wire and the comparators fed by the bus
`timescale 1ns/1ps
module can_bus_model
(
    input wire logic other_dom,
    input wire logic open_h,
    input wire logic txd_pin,
    input wire logic driver_en,
    output logic diff_rx_pin,
    output logic se_h_pin,
    output logic se_l_pin,
    output logic wake_h_pin,
    output logic wake_l_pin
);
    logic bus_dom;
    assign bus_dom = other_dom || (!txd_pin && driver_en);
    assign diff_rx_pin = !bus_dom;
    assign se_h_pin = bus_dom && !open_h;
    assign se_l_pin = !bus_dom;
    assign wake_h_pin = bus_dom;
    assign wake_l_pin = !bus_dom;
endmodule : can_bus_model

//--- tb/fault_diag_props.sv
// Concurrent checks on the ports of the CAN diagnosis and wake block
`timescale 1ns/1ps
module fault_diag_props
    import fault_diag_pkg::*;
#(
    parameter int TX_TIMEOUT = TX_TIMEOUT_CYC
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    input wire logic txd_pin,
    input wire logic driver_en,
    input wire logic int_pulse,
    input wire logic [1:0] can_mode,
    input wire logic [2:0] sbc_mode
);
    logic [15:0] low_cnt_r;
    // Cycles the transmit input has been held low, saturating
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            low_cnt_r <= 16'h0000;
        else if (txd_pin)
            low_cnt_r <= 16'h0000;
        else if (low_cnt_r != 16'hFFFF)
            low_cnt_r <= low_cnt_r + 16'h0001;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    apb_wait_state_a: assert property (psel && penable && !pready |=> pready)
        else $error("pready missing after access cycle");
    ready_one_cycle_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    slverr_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    int_single_a: assert property (int_pulse |=> !int_pulse)
        else $error("interrupt pulse too long");
    sleep_exit_a: assert property (sbc_mode == SBC_SLEEP && !psel |=>
        sbc_mode == SBC_SLEEP || sbc_mode == SBC_NORMREQ) else $error("bad exit from sleep");
    lowpower_term_a: assert property (sbc_mode == SBC_STOP ##1 sbc_mode == SBC_STOP
        |-> can_mode == CAN_MODE_TERM) else $error("cell not terminated in stop");
    stuck_off_a: assert property (low_cnt_r > TX_TIMEOUT + 5 |-> !driver_en)
        else $error("driver on with transmit stuck");
    int_seen_c: cover property (int_pulse);
    refused_c: cover property (pslverr);
    stuck_c: cover property (low_cnt_r > TX_TIMEOUT + 5);
endmodule : fault_diag_props
bind can_fault_diag_wake_logic fault_diag_props #(.TX_TIMEOUT(TX_TIMEOUT)) i_fault_diag_props
    (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .prdata, .txd_pin, .driver_en,
    .int_pulse, .can_mode, .sbc_mode);

//--- tb/tb_top.sv
// Testbench: register access, stuck transmit, ground shift, open wire and wake
`timescale 1ns/1ps
module tb_top;
    import fault_diag_pkg::*;
    localparam int TXTO = 50;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic txd_pin = 1'b1;
    logic other_dom = 1'b0;
    logic open_h = 1'b0;
    logic [3:0] gnd_cmp_pin = 4'hF;
    logic por_event = 1'b0;
    logic pready, pslverr, rxd_pin, driver_en, int_pulse, open_wire_flag;
    logic diff_rx_pin, se_h_pin, se_l_pin, wake_h_pin, wake_l_pin, err_bit;
    logic [31:0] prdata, rd;
    logic [1:0] can_mode;
    logic [2:0] sbc_mode;
    int errors = 0;
    int checked = 0;
    int pulses;
    always #25 pclk = ~pclk;
    can_fault_diag_wake_logic #(.VARIANT(VARIANT_SECOND), .TX_TIMEOUT(TXTO))
        i_can_fault_diag_wake_logic (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pready, .pslverr, .prdata, .txd_pin, .diff_rx_pin, .se_h_pin, .se_l_pin,
        .wake_h_pin, .wake_l_pin, .gnd_cmp_pin, .por_event, .rxd_pin, .driver_en,
        .int_pulse, .can_mode, .sbc_mode, .open_wire_flag);
    can_bus_model i_can_bus_model (.other_dom, .open_h, .txd_pin, .driver_en, .diff_rx_pin,
        .se_h_pin, .se_l_pin, .wake_h_pin, .wake_l_pin);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
        begin
            n++;
            @(posedge pclk);
        end
        chk(32'(n), 32'h1);
        rd = prdata;
        err_bit = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd & m, e);
    endtask : rchk
    task automatic tx_fall();
        @(posedge pclk);
        txd_pin <= 1'b0;
        repeat (4) @(posedge pclk);
        txd_pin <= 1'b1;
        repeat (4) @(posedge pclk);
    endtask : tx_fall
    task automatic wake();
        @(posedge pclk);
        other_dom <= 1'b1;
        pulses = 0;
        repeat (400)
        begin
            @(posedge pclk);
            if (int_pulse === 1'b1)
                pulses++;
        end
        other_dom <= 1'b0;
        repeat (10) @(posedge pclk);
    endtask : wake
    task automatic give_verdict();
        if (errors == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict
    initial
    begin
        repeat (20000) @(posedge pclk);
        errors++;
        $display("Error at %0t: run did not finish", $time);
        give_verdict();
    end
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        chk(32'(sbc_mode), 32'h7);
        chk(32'(rxd_pin), 32'h1);
        rchk(ADDR_RCR, 32'hF, 32'h0);
        apb(1'b1, ADDR_MODE, 32'h0);
        chk(32'(sbc_mode), 32'h0);
        rchk(8'h1C, 32'hFFFFFFFF, 32'h0);
        chk(32'(err_bit), 32'h1);
        apb(1'b1, ADDR_CAN, 32'h1);
        rchk(ADDR_CAN, 32'h3, 32'h1);
        for (int k = 0; k < 4; k++)
        begin
            apb(1'b1, ADDR_IOR, 32'(k));
            gnd_cmp_pin <= ~(4'h1 << k);
            tx_fall();
            rchk(ADDR_IOR, 32'h7, 32'(k) | 32'h4);
            rchk(ADDR_IOR, 32'h7, 32'(k));
        end
        gnd_cmp_pin <= 4'hE;
        tx_fall();
        rchk(ADDR_IOR, 32'h7, 32'h3);
        txd_pin <= 1'b0;
        repeat (TXTO - 10) @(posedge pclk);
        chk(32'(driver_en), 32'h1);
        repeat (20) @(posedge pclk);
        chk(32'(driver_en), 32'h0);
        rchk(ADDR_RCR, 32'h2, 32'h2);
        txd_pin <= 1'b1;
        repeat (600) @(posedge pclk);
        chk(32'(driver_en), 32'h0);
        repeat (60) @(posedge pclk);
        chk(32'(driver_en), 32'h1);
        apb(1'b1, ADDR_CAN, 32'h2);
        open_h <= 1'b1;
        // Bits longer than the sampling window; four faulty bits, then four healthy
        for (int k = 0; k < 8; k++)
        begin
            if (k == 4)
                open_h <= 1'b0;
            other_dom <= 1'b1;
            repeat (40) @(posedge pclk);
            chk(32'(rxd_pin), 32'h0);
            other_dom <= 1'b0;
            repeat (40) @(posedge pclk);
            if (k == 0)
                chk(32'(open_wire_flag), 32'h0);
            if (k == 3)
                rchk(ADDR_CAN, 32'hB, 32'hA);
            if (k == 6)
                chk(32'(open_wire_flag), 32'h1);
        end
        chk(32'(open_wire_flag), 32'h0);
        apb(1'b1, ADDR_CAN, 32'h0);
        other_dom <= 1'b1;
        repeat (300) @(posedge pclk);
        chk(32'(rxd_pin), 32'h1);
        repeat (40) @(posedge pclk);
        chk(32'(rxd_pin), 32'h0);
        repeat (60) @(posedge pclk);
        other_dom <= 1'b0;
        repeat (10) @(posedge pclk);
        chk(32'(rxd_pin), 32'h1);
        rchk(ADDR_RCR, 32'h1, 32'h0);
        apb(1'b1, ADDR_CAN, 32'h1);
        apb(1'b1, ADDR_MODE, 32'h2);
        repeat (2) @(posedge pclk);
        chk(32'(can_mode), 32'h0);
        wake();
        chk(32'(sbc_mode), 32'h6);
        rchk(ADDR_RCR, 32'h1, 32'h1);
        apb(1'b1, ADDR_MODE, 32'h0);
        apb(1'b1, ADDR_MODE, 32'h3);
        wake();
        chk(32'(pulses), 32'h1);
        rchk(ADDR_RCR, 32'h1, 32'h1);
        rchk(ADDR_RCR, 32'h1, 32'h0);
        // Power-on reset condition in mid-run
        apb(1'b1, ADDR_IOR, 32'h2);
        por_event <= 1'b1;
        repeat (4) @(posedge pclk);
        por_event <= 1'b0;
        repeat (4) @(posedge pclk);
        chk(32'(sbc_mode), 32'h7);
        chk(32'(can_mode), 32'h0);
        rchk(ADDR_IOR, 32'h3, 32'h0);
        give_verdict();
    end
endmodule : tb_top

//--- verilog/can_fault_diag_wake_logic.sv
// CAN fault diagnosis, stuck transmit, wake reporting and ground shift logic
`timescale 1ns/1ps
module can_fault_diag_wake_logic
    import fault_diag_pkg::*;
#(
    parameter int VARIANT = VARIANT_SECOND,
    parameter int TX_TIMEOUT = TX_TIMEOUT_CYC
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    input wire logic txd_pin,
    input wire logic diff_rx_pin,
    input wire logic se_h_pin,
    input wire logic se_l_pin,
    input wire logic wake_h_pin,
    input wire logic wake_l_pin,
    input wire logic [3:0] gnd_cmp_pin,
    input wire logic por_event,
    output logic rxd_pin,
    output logic driver_en,
    output logic int_pulse,
    output logic [1:0] can_mode,
    output logic [2:0] sbc_mode,
    output logic open_wire_flag
);
    typedef struct packed {
        logic [1:0][10:0] sync;
        logic tx_prev;
        logic diff_prev;
        logic [$clog2(TX_TIMEOUT + 1) - 1:0] dom_cnt;
        logic [9:0] rec_cnt;
        logic tx_stuck;
        logic [9:0] wake_cnt;
        logic bus_active;
        logic bus_wake;
        logic shift;
        logic [1:0] shift_sel;
        logic [1:0] can_sel;
        sbc_mode_e mode;
        logic int_p;
        logic ready;
        logic [31:0] rdata;
        logic err;
    } top_s;

    top_s st_r;
    top_s st_nxt;
    logic tx_s;
    logic diff_s;
    logic se_h_s;
    logic se_l_s;
    logic wake_h_s;
    logic wake_l_s;
    logic [3:0] gnd_s;
    logic por_s;
    logic term_mode;
    logic low_power;
    logic access;
    logic ow_flag;
    logic ow_clear;

    initial
    begin
        if (TX_TIMEOUT < 2 || TX_TIMEOUT > 1048575)
            $error("can_fault_diag_wake_logic: TX_TIMEOUT out of range");
        if (VARIANT != VARIANT_FIRST && VARIANT != VARIANT_SECOND)
            $error("can_fault_diag_wake_logic: unsupported variant");
    end

    function automatic logic [31:0] read_word(input logic [7:0] addr, input top_s s,
        input logic ow);
        logic [31:0] w;
        w = 32'h0;
        case (addr)
            ADDR_MODE: w[2:0] = s.mode;
            ADDR_RCR:
            begin
                w[RCR_BUS_WAKE_BIT] = s.bus_wake;
                w[RCR_TX_STUCK_BIT] = s.tx_stuck;
            end
            ADDR_CAN: w[3:0] = {ow, 1'b0, s.can_sel};
            ADDR_IOR: w[3:0] = {1'b0, s.shift, s.shift_sel};
            default: w = 32'h0;
        endcase
        return w;
    endfunction : read_word

    function automatic logic addr_ok(input logic [7:0] addr);
        return addr == ADDR_MODE || addr == ADDR_RCR || addr == ADDR_CAN || addr == ADDR_IOR;
    endfunction : addr_ok

    assign {tx_s, diff_s, se_h_s, se_l_s, wake_h_s, wake_l_s, gnd_s, por_s} = st_r.sync[1];
    assign low_power = (st_r.mode == SBC_SLEEP) || (st_r.mode == SBC_STOP);
    assign term_mode = low_power || (st_r.can_sel == CAN_MODE_TERM);
    assign access = psel && penable && !st_r.ready;
    assign ow_clear = por_s || (st_r.mode == SBC_RESET);

    open_wire_counter #(
        .VARIANT(VARIANT)
    ) u_open_wire (
        .pclk(pclk),
        .presetn(presetn),
        .clear(ow_clear),
        .diff_rx(diff_s),
        .diff_edge(diff_s != st_r.diff_prev),
        .se_h(se_h_s),
        .se_l(se_l_s),
        .receiving(!term_mode && tx_s),
        .open_flag(ow_flag)
    );

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.sync[0] = {txd_pin, diff_rx_pin, se_h_pin, se_l_pin, wake_h_pin, wake_l_pin,
            gnd_cmp_pin, por_event};
        st_nxt.sync[1] = st_r.sync[0];
        st_nxt.tx_prev = tx_s;
        st_nxt.diff_prev = diff_s;
        st_nxt.int_p = 1'b0;
        // Stuck dominant supervision, transmit low is dominant
        if (!tx_s)
        begin
            st_nxt.rec_cnt = '0;
            if (st_r.dom_cnt < ($bits(st_r.dom_cnt))'(TX_TIMEOUT))
                st_nxt.dom_cnt = st_r.dom_cnt + 1'b1;
            else
                st_nxt.tx_stuck = 1'b1;
        end
        else
        begin
            st_nxt.dom_cnt = '0;
            if (st_r.rec_cnt < 10'(TX_RECOVER_CYC))
                st_nxt.rec_cnt = st_r.rec_cnt + 10'h001;
            else
                st_nxt.tx_stuck = 1'b0;
        end
        // Wake filter on both wake comparators
        if (term_mode && (wake_h_s || !wake_l_s))
        begin
            if (st_r.wake_cnt < 10'(WAKE_FILT_CYC))
                st_nxt.wake_cnt = st_r.wake_cnt + 10'h001;
            else if (!st_r.bus_active)
            begin
                st_nxt.bus_active = 1'b1;
                if (st_r.mode == SBC_SLEEP)
                begin
                    st_nxt.mode = SBC_NORMREQ;
                    st_nxt.bus_wake = 1'b1;
                end
                else if (st_r.mode == SBC_STOP)
                begin
                    st_nxt.int_p = 1'b1;
                    st_nxt.bus_wake = 1'b1;
                end
            end
        end
        else
        begin
            st_nxt.wake_cnt = '0;
            st_nxt.bus_active = 1'b0;
        end
        // Ground shift at transmit falling edge, single unfiltered sample
        if (st_r.tx_prev && !tx_s && !gnd_s[st_r.shift_sel])
            st_nxt.shift = 1'b1;
        // APB access, one wait state
        st_nxt.ready = access;
        st_nxt.err = access && !addr_ok(paddr);
        st_nxt.rdata = access && !pwrite ? read_word(paddr, st_r, ow_flag) : 32'h0;
        if (access && pwrite)
        begin
            case (paddr)
                ADDR_MODE:
                    // Codes without a mode are ignored
                    if (pwdata[2:0] != 3'h4 && pwdata[2:0] != 3'h5)
                        st_nxt.mode = sbc_mode_e'(pwdata[2:0]);
                ADDR_CAN: st_nxt.can_sel = pwdata[1:0];
                ADDR_IOR: st_nxt.shift_sel = pwdata[1:0];
                default: st_nxt.can_sel = st_r.can_sel;
            endcase
        end
        // Read clears bus wake and ground shift flags, not tx_stuck; a new set in the same cycle wins
        if (access && !pwrite && paddr == ADDR_RCR
            && !(st_nxt.bus_active && !st_r.bus_active && low_power))
            st_nxt.bus_wake = 1'b0;
        if (access && !pwrite && paddr == ADDR_IOR && !(st_r.tx_prev && !tx_s))
            st_nxt.shift = 1'b0;
        // Reset conditions of the register bits
        if (por_s)
        begin
            st_nxt.bus_wake = 1'b0;
            st_nxt.can_sel = CAN_MODE_TERM;
            st_nxt.shift_sel = 2'h0;
            st_nxt.shift = 1'b0;
            st_nxt.mode = SBC_RESET;
        end
        else if (st_r.mode == SBC_RESET)
        begin
            st_nxt.can_sel = CAN_MODE_TERM;
            st_nxt.shift_sel = 2'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r <= '0;
            st_r.sync <= {2{PIN_IDLE}};
            st_r.tx_prev <= 1'b1;
            st_r.diff_prev <= 1'b1;
            st_r.mode <= SBC_RESET;
        end
        else
            st_r <= st_nxt;
    end

    assign pready = st_r.ready;
    assign pslverr = st_r.err;
    assign prdata = st_r.rdata;
    // Activity report on receive, second variant outside sleep and stop only
    assign rxd_pin = (VARIANT == VARIANT_SECOND && term_mode && !low_power
        && st_r.bus_active) ? 1'b0 : (term_mode ? 1'b1 : diff_s);
    assign driver_en = !st_r.tx_stuck && !term_mode && st_r.can_sel == CAN_MODE_TXRX;
    assign int_pulse = st_r.int_p;
    assign can_mode = term_mode ? CAN_MODE_TERM : st_r.can_sel;
    assign sbc_mode = st_r.mode;
    assign open_wire_flag = ow_flag;
endmodule : can_fault_diag_wake_logic

//--- verilog/fault_diag_pkg.sv
// Package with constants and types of the CAN fault diagnosis and wake logic
// Functional notes
// - Open wire only reported; driver and receiver never change for it.
// - Open wire: differential receiver toggles, one single-ended receiver does not.
// - Single-ended receivers sampled inside a 1 us window after differential switch.
// - Each mismatch increments counter; at four an open wire is flagged.
// - Open-wire counting only while receiving, suspended while transmitting.
// - First variant: after flag, dominant samples decrement; zero means recovered.
// - Second variant: dominant decrements, recessive increments to four; zero recovers.
// - Transmit dominant beyond timeout disables the bus driver.
// - Stuck dominant sets status bit D1 of reset configuration register.
// - Driver re-enabled after transmit recessive longer than recovery time.
// - Second variant, battery terminated, normal/standby: bus dominant shows low on receive.
// - Receive low starts after 16 us wake filter; lasts bus dominant minus filter.
// - Activity report uses wake comparators of both lines, works with wire faults.
// - Wake in sleep moves to normal request and sets bus wake flag.
// - Wake in stop pulses interrupt output and sets bus wake flag.
// - Wake in normal/standby leaves flag clear; only second variant pulses receive.
// - Ground shift threshold selectable over serial port from four levels.
// - At transmit falling edge, high line below threshold sets ground shift flag.
// - Ground shift has no filter; one sample sets flag; software repeats checks.
// - Serial frame: three address bits, read/write bit, four data bits; the code uses an APB port with 32-bit words instead.
// - Write frame output meaningless; read frame last four bits carry register.
// - Register bits return to reset values on their listed reset conditions.
// - Transmit low requests dominant, high requests recessive.
// - CAN cell modes selected by port; battery terminated forced in sleep/stop.
package fault_diag_pkg;
    localparam int CLK_HZ = 20000000;
    localparam int SAMPLE_WIN_NS = 1000;
    localparam int SAMPLE_WIN_CYC = (SAMPLE_WIN_NS * (CLK_HZ / 1000000)) / 1000;
    localparam int TX_TIMEOUT_US = 750;
    localparam int TX_TIMEOUT_CYC = (TX_TIMEOUT_US * (CLK_HZ / 1000000));
    localparam int TX_RECOVER_US = 32;
    localparam int TX_RECOVER_CYC = TX_RECOVER_US * (CLK_HZ / 1000000);
    localparam int WAKE_FILT_US = 16;
    localparam int WAKE_FILT_CYC = WAKE_FILT_US * (CLK_HZ / 1000000);
    localparam logic [2:0] OPEN_LIMIT = 3'h4;
    // Idle pin levels: tx, diff rx, se_l, wake_l high, se_h, wake_h low, gnd comparators high, no por
    localparam logic [10:0] PIN_IDLE = 11'h6BE;
    localparam int VARIANT_FIRST = 0;
    localparam int VARIANT_SECOND = 1;
    // Register map, byte addresses of APB words
    localparam logic [7:0] ADDR_RCR = 8'h04;
    localparam logic [7:0] ADDR_CAN = 8'h08;
    localparam logic [7:0] ADDR_IOR = 8'h0C;
    localparam logic [7:0] ADDR_MODE = 8'h00;
    localparam int RCR_BUS_WAKE_BIT = 0;
    localparam int RCR_TX_STUCK_BIT = 1;
    localparam int IOR_SHIFT_BIT = 2;
    localparam logic [1:0] CAN_MODE_TERM = 2'h0;
    localparam logic [1:0] CAN_MODE_TXRX = 2'h1;
    localparam logic [1:0] CAN_MODE_RXONLY = 2'h2;
    typedef enum logic [2:0] {
        SBC_NORMAL = 3'h0,
        SBC_STANDBY = 3'h1,
        SBC_STOP = 3'h3,
        SBC_SLEEP = 3'h2,
        SBC_NORMREQ = 3'h6,
        SBC_RESET = 3'h7
    } sbc_mode_e;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_s;
    typedef struct packed {
        logic [2:0] count;
        logic flagged;
        logic [4:0] win;
        logic armed;
        logic [1:0] se_start;
    } open_wire_s;
endpackage : fault_diag_pkg

//--- verilog/open_wire_counter.sv
// Open wire detection and recovery counter for one differential receiver pair
`timescale 1ns/1ps
module open_wire_counter
    import fault_diag_pkg::*;
#(
    parameter int VARIANT = VARIANT_SECOND
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clear,
    input wire logic diff_rx,
    input wire logic diff_edge,
    input wire logic se_h,
    input wire logic se_l,
    input wire logic receiving,
    output logic open_flag
);
    open_wire_s st_r;
    open_wire_s st_nxt;
    logic mismatch;
    logic se_dom;

    initial
    begin
        if (VARIANT != VARIANT_FIRST && VARIANT != VARIANT_SECOND)
            $error("open_wire_counter: unsupported variant");
    end

    // Sample ends inside the window: one single-ended receiver did not follow
    assign mismatch = st_r.armed && (st_r.win == 5'h01)
        && ((se_h != st_r.se_start[1]) != (se_l != st_r.se_start[0]));
    // Dual-wire dominant: both single-ended receivers report dominant
    assign se_dom = se_h && !se_l;

    always_comb
    begin
        st_nxt = st_r;
        // An edge inside a running window is not sampled on its own
        if (diff_edge && receiving && !st_r.armed)
        begin
            // se_start still holds the levels from before the edge
            st_nxt.armed = 1'b1;
            st_nxt.win = 5'(SAMPLE_WIN_CYC);
        end
        else if (st_r.armed)
        begin
            st_nxt.win = st_r.win - 5'h01;
            if (st_r.win == 5'h01)
            begin
                st_nxt.armed = 1'b0;
                if (!st_r.flagged)
                begin
                    if (mismatch)
                        st_nxt.count = st_r.count + 3'h1;
                    if (mismatch && st_r.count + 3'h1 == OPEN_LIMIT)
                        st_nxt.flagged = 1'b1;
                end
                else if (!diff_rx)
                begin
                    // Recovery samples are taken in dominant windows only
                    if (se_dom)
                    begin
                        st_nxt.count = st_r.count - 3'h1;
                        if (st_r.count == 3'h1)
                            st_nxt.flagged = 1'b0;
                    end
                    else if (VARIANT == VARIANT_SECOND && st_r.count < OPEN_LIMIT)
                        st_nxt.count = st_r.count + 3'h1;
                end
            end
        end
        else
            st_nxt.se_start = {se_h, se_l};
        if (!receiving)
            st_nxt.armed = 1'b0;
        if (clear)
            st_nxt = '0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign open_flag = st_r.flagged;
endmodule : open_wire_counter
